// >>> sarx_map.vh
// Purpose: register map, field positions, reset values and framing codes
// Assumes: byte-wide registers reached over a simple write/read register port
// Notes: shared by the channel-map top and its capture module
//
// Notes on behaviour
// R1: a receive channel takes its data from the primary data pin when its select bit is 0 and from the secondary data pin when it is 1.
// R2: the pin-select register holds one bit per channel, channel 8 at bit 7 down to channel 1 at bit 0.
// R3: the pin-select register resets to zero so every channel starts on the primary data pin.
// R4: a channel whose enable bit 5 is 0 is disabled, and when it is 1 its data feeds the DAC channel of the same number.
// Only channels 1 and 2 do so here; setting bit 5 of the channel 3 config feeds nothing.
// R5: bits 4 to 0 hold a slot number, and in TDM framing value n selects slot n for n from 0 to 31.
// R6: in I2S or left-justified framing, values 0 to 15 select slots 0 to 15 of the left half.
// R7: in I2S or left-justified framing, values 16 to 31 select slots 0 to 15 of the right half.
// R8: channel 1 resets enabled on slot 0, register value 0x20.
// R9: channel 2 resets enabled on slot 1, register value 0x21.
// R10: the channel 3 configuration register resets to 0x02.
// R11: bits 7 and 6 of each channel configuration register are reserved and read-only, and software writes their reset values there.
// R12: each frame, each enabled channel captures the word in its assigned slot on its selected pin and passes it to its DAC channel.
// Only channels 1 and 2 have a capture engine here; an enabled channel 3 captures nothing.
`ifndef SARX_MAP_VH
`define SARX_MAP_VH
`define SARX_OFS_PIN_SEL 8'h27
`define SARX_OFS_CH1_CFG 8'h28
`define SARX_OFS_CH2_CFG 8'h29
`define SARX_OFS_CH3_CFG 8'h2a
`define SARX_RST_PIN_SEL 8'h00
`define SARX_RST_CH1_CFG 8'h20
`define SARX_RST_CH2_CFG 8'h21
`define SARX_RST_CH3_CFG 8'h02
`define SARX_BIT_ENABLE 5
`define SARX_SLOT_MSB 4
`define SARX_RW_MASK 8'h3f
`define SARX_FMT_TDM 2'h0
`define SARX_FMT_I2S 2'h1
`define SARX_FMT_LJ 2'h2
`define SARX_WORD_BITS 32
`define SARX_SLOT_BITS 32
`define SARX_SLOT_LAST 5'h1f
`endif

// >>> sarx_capture.v
// Purpose: capture one slot word per frame from one serial data stream
// Assumes: bit clock edges and frame starts already found in the system clock domain
// Notes: slot width is fixed at 32 bit clocks; msb first
`timescale 1ns/10ps
`include "sarx_map.vh"
module sarx_capture (
    clk,
    sys_rst,
    bit_rise,
    frame_start,
    half_start,
    fmt,
    din,
    enable,
    slot,
    word,
    word_valid
);
    input wire clk;
    input wire sys_rst;
    input wire bit_rise;
    input wire frame_start;
    input wire half_start;
    input wire [1:0] fmt;
    input wire din;
    input wire enable;
    input wire [4:0] slot;
    output reg [31:0] word;
    output reg word_valid;

    reg [9:0] bit_pos;
    reg [31:0] shift;
    reg right_half;
    wire restart;
    wire [9:0] cur_pos;
    wire cur_right;
    wire [31:0] next_shift;
    wire [4:0] target;
    wire want_right;

    // split slot code into half select and slot index
    assign want_right = (fmt != `SARX_FMT_TDM) && slot[4]; // R7
    assign target = (fmt == `SARX_FMT_TDM) ? slot : {1'b0, slot[3:0]}; // R5 R6

    // the bit at a frame start, or at a half start outside tdm, is already bit 0 of slot 0
    assign restart = frame_start || (half_start && fmt != `SARX_FMT_TDM);
    assign cur_pos = restart ? 10'h000 : bit_pos;
    assign cur_right = frame_start ? 1'b0 : (restart ? 1'b1 : right_half);
    assign next_shift = {shift[30:0], din};

    // bit position tracking, shift register and capture
    always @(posedge clk) begin
        word_valid <= 1'b0;
        if (sys_rst) begin
            bit_pos <= 10'h000;
            shift <= 32'h00000000;
            right_half <= 1'b0;
            word <= 32'h00000000;
        end else if (bit_rise) begin
            shift <= next_shift;
            bit_pos <= cur_pos + 10'h001;
            right_half <= cur_right;
            // last bit of the wanted slot in the wanted half
            if (enable && cur_pos[4:0] == `SARX_SLOT_LAST && cur_pos[9:5] == target
                    && cur_right == want_right) begin // R4 R12
                word <= next_shift;
                word_valid <= 1'b1;
            end
        end
    end
endmodule

// >>> sarx_channel_map.v
// Purpose: receive channel mapping of the primary serial port
// Assumes: host drives bit clock and frame sync; data sampled on bit clock rise
// Assumes: bit clock period of at least eight system clocks
// Notes: channels 1 and 2 feed DAC channels; select bits kept for all eight
// Notes: channels 3 to 8 keep only their select bits, channel 3 its config too
// Notes: frame format arrives on a port, not from a register here
`timescale 1ns/10ps
`include "sarx_map.vh"
module sarx_channel_map (
    clk,
    sys_rst,
    reg_wr,
    reg_addr,
    reg_wdata,
    reg_rdata,
    fmt,
    bit_clk,
    frame_sync,
    primary_data_in,
    secondary_data_input_pin,
    dac_ch1_data,
    dac_ch1_valid,
    dac_ch2_data,
    dac_ch2_valid,
    rx_data_pin_select
);
    input wire clk;
    input wire sys_rst;
    input wire reg_wr;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    input wire [1:0] fmt;
    input wire bit_clk;
    input wire frame_sync;
    input wire primary_data_in;
    input wire secondary_data_input_pin;
    output wire [31:0] dac_ch1_data;
    output wire dac_ch1_valid;
    output wire [31:0] dac_ch2_data;
    output wire dac_ch2_valid;
    output reg [7:0] rx_data_pin_select;

    // configuration registers and their next values
    reg [7:0] rx_channel1_config;
    reg [7:0] rx_channel2_config;
    reg [7:0] rx_channel3_config;
    reg [7:0] next_pin_select;
    reg [7:0] next_ch1_config;
    reg [7:0] next_ch2_config;
    reg [7:0] next_ch3_config;
    wire [3:0] reg_hit;
    wire [3:0] reg_wr_hit;

    // synchronised pins: bit clock, frame sync, primary data, secondary data
    wire [3:0] pin_raw;
    wire [3:0] pin_next;
    wire [3:0] pin_state;

    // frame timing
    reg fs_prev;
    wire bit_rise;
    wire fs_level;
    wire frame_start;
    wire half_start;

    // per-channel capture wiring, index 0 is channel 1
    wire [1:0] ch_din;
    wire [1:0] ch_enable;
    wire [9:0] ch_slot;
    wire [63:0] ch_word;
    wire [1:0] ch_valid;
    genvar gi;

    // merge a write into a channel config, keeping reserved bits
    function [7:0] cfg_write;
        input [7:0] old_val;
        input [7:0] new_val;
        begin
            cfg_write = (old_val & ~`SARX_RW_MASK) | (new_val & `SARX_RW_MASK); // R11
        end
    endfunction

    // one-hot register select of an offset, none for unmapped offsets
    function [3:0] reg_decode;
        input [7:0] addr;
        begin
            case (addr)
                `SARX_OFS_PIN_SEL: reg_decode = 4'h1;
                `SARX_OFS_CH1_CFG: reg_decode = 4'h2;
                `SARX_OFS_CH2_CFG: reg_decode = 4'h4;
                `SARX_OFS_CH3_CFG: reg_decode = 4'h8;
                default: reg_decode = 4'h0;
            endcase
        end
    endfunction

    // addressed register, shared by write and read
    assign reg_hit = reg_decode(reg_addr);

    // write strobe per register
    assign reg_wr_hit = reg_hit & {4{reg_wr}};

    // next register values; a write replaces only writable bits
    always @* begin
        next_pin_select = rx_data_pin_select;
        next_ch1_config = rx_channel1_config;
        next_ch2_config = rx_channel2_config;
        next_ch3_config = rx_channel3_config;
        if (reg_wr_hit[0]) begin
            next_pin_select = reg_wdata; // R2
        end
        if (reg_wr_hit[1]) begin
            next_ch1_config = cfg_write(rx_channel1_config, reg_wdata);
        end
        if (reg_wr_hit[2]) begin
            next_ch2_config = cfg_write(rx_channel2_config, reg_wdata);
        end
        if (reg_wr_hit[3]) begin
            next_ch3_config = cfg_write(rx_channel3_config, reg_wdata);
        end
    end

    // register update; reset puts every channel on the primary pin
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_data_pin_select <= `SARX_RST_PIN_SEL; // R3
            rx_channel1_config <= `SARX_RST_CH1_CFG; // R8
            rx_channel2_config <= `SARX_RST_CH2_CFG; // R9
            rx_channel3_config <= `SARX_RST_CH3_CFG; // R10
        end else begin
            rx_data_pin_select <= next_pin_select;
            rx_channel1_config <= next_ch1_config;
            rx_channel2_config <= next_ch2_config;
            rx_channel3_config <= next_ch3_config;
        end
    end

    // register readback, unmapped reads zero
    always @* begin
        case (reg_hit)
            4'h1: reg_rdata = rx_data_pin_select;
            4'h2: reg_rdata = rx_channel1_config;
            4'h4: reg_rdata = rx_channel2_config;
            4'h8: reg_rdata = rx_channel3_config;
            default: reg_rdata = 8'h00;
        endcase
    end

    // pins gathered in synchroniser order
    assign pin_raw = {secondary_data_input_pin, primary_data_in, frame_sync, bit_clk};

    // three-stage synchroniser per pin; a change counts once stages 2 and 3 agree
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            reg [2:0] stage;
            reg state;
            always @(posedge clk) begin
                if (sys_rst) begin
                    stage <= 3'h0;
                    state <= 1'b0;
                end else begin
                    stage <= {stage[1:0], pin_raw[gi]};
                    if (stage[1] == stage[2]) begin
                        state <= stage[2];
                    end
                end
            end
            assign pin_next[gi] = (stage[1] == stage[2]) ? stage[2] : state;
            assign pin_state[gi] = state;
        end
    endgenerate

    // bit clock rise, one system clock wide
    assign bit_rise = pin_next[0] && !pin_state[0];

    // frame sync taken at bit clock rise; i2s frames start on the low level
    assign fs_level = (fmt == `SARX_FMT_I2S) ? !pin_next[1] : pin_next[1];
    assign frame_start = bit_rise && fs_level && !fs_prev;
    assign half_start = bit_rise && !fs_level && fs_prev;

    // active frame level as seen at the previous bit clock rise
    always @(posedge clk) begin
        if (sys_rst) begin
            fs_prev <= 1'b0;
        end else if (bit_rise) begin
            fs_prev <= fs_level;
        end
    end

    // enable and slot fields of channels 1 and 2
    assign ch_enable[0] = rx_channel1_config[`SARX_BIT_ENABLE]; // R4
    assign ch_enable[1] = rx_channel2_config[`SARX_BIT_ENABLE]; // R4
    assign ch_slot[4:0] = rx_channel1_config[`SARX_SLOT_MSB:0]; // R5
    assign ch_slot[9:5] = rx_channel2_config[`SARX_SLOT_MSB:0]; // R5

    // one capture engine per DAC channel, fed from its chosen pin
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            assign ch_din[gi] = rx_data_pin_select[gi] ? pin_next[3] : pin_next[2]; // R1
            sarx_capture u_cap (
                .clk(clk),
                .sys_rst(sys_rst),
                .bit_rise(bit_rise),
                .frame_start(frame_start),
                .half_start(half_start),
                .fmt(fmt),
                .din(ch_din[gi]),
                .enable(ch_enable[gi]),
                .slot(ch_slot[gi * 5 +: 5]),
                .word(ch_word[gi * 32 +: 32]),
                .word_valid(ch_valid[gi])
            );
        end
    endgenerate

    // channel 1 to its DAC channel
    assign dac_ch1_data = ch_word[31:0];
    assign dac_ch1_valid = ch_valid[0];

    // channel 2 to its DAC channel
    assign dac_ch2_data = ch_word[63:32];
    assign dac_ch2_valid = ch_valid[1];
endmodule

// >>> sarx_props.sv
// Purpose: port-level checks of the receive channel map
// Assumes: sync active-high reset, combinational read port
// Notes: bound to the top module
`timescale 1ns/10ps
module sarx_props (
    input wire clk,
    input wire sys_rst,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [31:0] dac_ch1_data,
    input wire dac_ch1_valid,
    input wire dac_ch2_valid,
    input wire [7:0] rx_data_pin_select
);
    reg [1:0] en;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // enable bits as last written
    always @(posedge clk) begin
        if (sys_rst)
            en <= 2'h3;
        else if (reg_wr && reg_addr[7:1] == 7'h14)
            en[reg_addr[0]] <= reg_wdata[5];
    end
    a_rst_sel_zero: assert property ($past(sys_rst) |-> rx_data_pin_select == 8'h00)
        else $error("pin select not clear after reset");
    a_rst_ch1_cfg: assert property ($past(sys_rst) && reg_addr == 8'h28 |-> reg_rdata == 8'h20)
        else $error("channel 1 config wrong after reset");
    a_rsvd_read_zero: assert property (reg_addr[7:1] == 7'h14 || reg_addr == 8'h2a
        |-> reg_rdata[7:6] == 2'h0)
        else $error("reserved config bits not zero");
    a_sel_write: assert property (reg_wr && reg_addr == 8'h27 |=> rx_data_pin_select == $past(reg_wdata))
        else $error("pin select write lost");
    a_sel_hold: assert property (!(reg_wr && reg_addr == 8'h27) |=> $stable(rx_data_pin_select))
        else $error("pin select changed without write");
    a_sel_read: assert property (reg_addr == 8'h27 |-> reg_rdata == rx_data_pin_select)
        else $error("pin select read differs");
    a_cfg_write_mask: assert property (reg_wr && reg_addr == 8'h29 ##1 reg_addr == 8'h29
        |-> reg_rdata == ($past(reg_wdata) & 8'h3f))
        else $error("channel 2 config write wrong");
    a_disabled_quiet: assert property (({dac_ch2_valid, dac_ch1_valid} & ~en) == 2'h0)
        else $error("disabled channel delivered a word");
    a_one_per_slot: assert property (dac_ch1_valid |=> !dac_ch1_valid [*8])
        else $error("channel 1 word pulses too close");
    a_data_cause: assert property ($changed(dac_ch1_data) |-> dac_ch1_valid)
        else $error("channel 1 data changed without pulse");
    c_ch1_word: cover property (dac_ch1_valid);
    c_ch2_word: cover property (dac_ch2_valid);
    c_sel_write: cover property (reg_wr && reg_addr == 8'h27);
endmodule
bind sarx_channel_map sarx_props u_props (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .dac_ch1_data, .dac_ch1_valid, .dac_ch2_valid, .rx_data_pin_select);

// >>> sarx_host.sv
// Purpose: host model sending serial audio frames
// Assumes: 400 ns bit clock, 32-bit slots msb first
// Notes: bit clock stands still between frames
`timescale 1ns/10ps
module sarx_host (
    output reg bit_clk,
    output reg frame_sync,
    output reg [1:0] dout
);
    reg [31:0] base;
    initial begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        dout = 2'b00;
        base = 32'h0;
    end
    // one half for tdm, two otherwise; n slots a half; secondary pin sends inverse
    task send(input [1:0] fmt, input integer n);
        integer h, b;
        reg [4:0] k;
        reg [31:0] w;
        begin
            frame_sync = (fmt == 2'h1);
            #413;
            for (h = 0; h < ((fmt == 2'h0) ? 1 : 2); h = h + 1) begin
                for (b = 0; b < n * 32; b = b + 1) begin
                    k = b / 32 + h * 16;
                    w = base ^ (k * 32'h01010101);
                    dout = {~w[31 - b % 32], w[31 - b % 32]};
                    frame_sync = (fmt == 2'h0) ? (b == 0) : (fmt == 2'h1) ? h[0] : ~h[0];
                    #200 bit_clk = 1'b1;
                    #200 bit_clk = 1'b0;
                end
            end
            frame_sync = (fmt == 2'h1);
            dout = ~dout;
        end
    endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the receive channel map
// Assumes: 50 ns system clock, host model drives the serial pins
// Notes: random slot maps from a fixed seed plus corner slots
`timescale 1ns/10ps
module tb;
    reg clk, sys_rst, reg_wr;
    reg [7:0] reg_addr, reg_wdata;
    reg [1:0] fmt;
    reg [31:0] r;
    wire [7:0] reg_rdata, sel_q;
    wire [1:0] din;
    wire [31:0] d1, d2;
    wire bit_clk, frame_sync, v1, v2;
    integer num_errors, total_checks, cyc, seed, i, p1, p2;
    sarx_channel_map u_dut (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .fmt,
        .bit_clk, .frame_sync, .primary_data_in(din[0]), .secondary_data_input_pin(din[1]),
        .dac_ch1_data(d1), .dac_ch1_valid(v1), .dac_ch2_data(d2), .dac_ch2_valid(v2),
        .rx_data_pin_select(sel_q));
    sarx_host u_host (.bit_clk, .frame_sync, .dout(din));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pulse counters and hang limit
    always @(posedge clk) begin
        p1 <= p1 + v1;
        p2 <= p2 + v2;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(negedge clk);
            reg_addr = a;
            #1 check({24'h0, reg_rdata}, {24'h0, e});
        end
    endtask
    function [31:0] exp_w(input [31:0] b, input [4:0] k, input p);
        exp_w = b ^ (k * 32'h01010101) ^ {32{p}};
    endfunction
    // configure, send one frame, compare both dac channels
    task run(input [1:0] f, input [7:0] s, input [1:0] en, input [4:0] k1, input [4:0] k2);
        integer n;
        reg [31:0] b;
        begin
            b = $random(seed);
            fmt = f;
            wr(8'h27, s);
            wr(8'h28, {2'h0, en[0], k1});
            wr(8'h29, {2'h0, en[1], k2});
            n = (f == 2'h0) ? k1 : k1 % 16;
            if (((f == 2'h0) ? k2 : k2 % 16) > n)
                n = (f == 2'h0) ? k2 : k2 % 16;
            u_host.base = b;
            p1 = 0;
            p2 = 0;
            u_host.send(f, n + 1);
            repeat (20) @(negedge clk);
            check(p1, {31'h0, en[0]});
            check(p2, {31'h0, en[1]});
            if (en[0])
                check(d1, exp_w(b, k1, s[0]));
            if (en[1])
                check(d2, exp_w(b, k2, s[1]));
            check({24'h0, sel_q}, {24'h0, s});
        end
    endtask
    task wrap_up;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        seed = 32'h8c5b;
        {num_errors, total_checks, cyc, p1, p2} = 160'h0;
        {sys_rst, reg_wr, reg_addr, reg_wdata, fmt} = {1'b1, 1'b0, 8'h28, 8'h00, 2'h0};
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h20);
        rd(8'h29, 8'h21);
        rd(8'h2a, 8'h02);
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h3f);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        run(2'h0, 8'h00, 2'h3, 5'h00, 5'h01);
        run(2'h0, 8'h02, 2'h1, 5'h1f, 5'h03);
        run(2'h1, 8'h01, 2'h3, 5'h1f, 5'h10);
        run(2'h2, 8'h03, 2'h2, 5'h0f, 5'h00);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            run(r[1:0], r[9:2], r[11:10], r[16:12] & 5'h11, r[21:17] & 5'h11);
        end
        wrap_up;
    end
endmodule
